// ==== verilog/mgw_map.svh ====
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with byte addresses on 12 address bits
`ifndef MGW_MAP_SVH
`define MGW_MAP_SVH
`define MGW_CTRL       12'h000
`define MGW_FLAGS      12'h004
`define MGW_ISTAT      12'h008
`define MGW_IMASK      12'h00c
`define MGW_MADDR      12'h010
`define MGW_MDATA      12'h014
`define MGW_CTRL_EN    0
`define MGW_CTRL_DECLR 1
`define MGW_CTRL_RST   1'b1
`define MGW_F_DE       0
`define MGW_F_WOK      1
`define MGW_EV_OK      0
`define MGW_EV_FAIL    1
`define MGW_EV_DROP    2
`define MGW_EVW        3
`define MGW_MD_LOCK    8
`define MGW_FAST_DELIM 11'h6e5
`define MGW_CRC_ACK    16'h1e0f
`define MGW_CRC_ACKOK  16'h0e2e
`define MGW_CRC_ERR    16'h00ff
`define MGW_CRC_ERROK  16'h10de
`define MGW_CRC_P0_WOK 16'h3e4d
`define MGW_CRC_P0_ALL 16'h2e6c
`define MGW_EE_WRITE_NS 13300000
`define MGW_CLK_NS     5
`endif

// ==== verilog/mgw_pkg.sv ====
// types shared by the masked group write and fast return block
// assumes the command decoder and the reply coder share pclk
package mgw_pkg;
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_BQW = 3'b001, CMD_WR = 3'b010,
    CMD_AQW = 3'b011, CMD_LOCK = 3'b100, CMD_LQ = 3'b101,
    CMD_PORT = 3'b110, CMD_OTHER = 3'b111
  } mgw_cmd_t;
  typedef enum logic [1:0] {
    TS_READY = 2'b00, TS_ID = 2'b01, TS_DE = 2'b10, TS_QUIET = 2'b11
  } mgw_tstate_t;
  typedef enum logic [2:0] {
    RK_ACK = 3'b000, RK_ACK_NOK = 3'b001, RK_ACK_OK = 3'b010,
    RK_ERR_NOK = 3'b011, RK_ERR = 3'b100, RK_ERR_OK = 3'b101
  } mgw_rkind_t;
  typedef struct packed {
    logic        valid;
    mgw_cmd_t    code;
    logic [10:0] delim;
    logic        id_match;
    logic [7:0]  addr;
    logic [7:0]  mask;
    logic [31:0] data;
    mgw_rkind_t  rkind;
  } mgw_cmd_s_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
    logic        crc_fixed;
    logic [15:0] crc;
  } mgw_rsp_t;
endpackage

// ==== verilog/mgw_top.sv ====
// masked group quad write and fast return link reply coding
// assumes cmd comes from a same-clock frame decoder, one-cycle valid
`timescale 1ns/10ps
`default_nettype none
`include "mgw_map.svh"
module mgw_top #(
  parameter int MEM_BYTES = 64,
  parameter int PROG_CYC  =
    (`MGW_EE_WRITE_NS + `MGW_CLK_NS - 1) / `MGW_CLK_NS
) (
  // clock, reset, enable
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // frame decoder side
  input  wire mgw_pkg::mgw_cmd_s_t cmd,
  input  wire mgw_pkg::mgw_tstate_t tag_state,
  // reply coder side
  output mgw_pkg::mgw_rsp_t        rsp,
  output logic                    de_enter,
  output logic                    irq
);
  localparam int AW = $clog2(MEM_BYTES);
  localparam int CW = $clog2(PROG_CYC + 1);

  initial begin
    if (MEM_BYTES < 4 || MEM_BYTES > 256 || (MEM_BYTES % 4) != 0)
      $error("MEM_BYTES must be 4..256 and a multiple of 4");
    if (PROG_CYC < 1) $error("PROG_CYC must be at least 1");
  end

  // fixed crc for a fast acknowledge or error reply
  function automatic logic [15:0] kind_crc(mgw_pkg::mgw_rkind_t k);
    unique case (k)
      mgw_pkg::RK_ACK, mgw_pkg::RK_ACK_NOK: kind_crc = `MGW_CRC_ACK;
      mgw_pkg::RK_ACK_OK:                  kind_crc = `MGW_CRC_ACKOK;
      mgw_pkg::RK_ERR, mgw_pkg::RK_ERR_NOK: kind_crc = `MGW_CRC_ERR;
      mgw_pkg::RK_ERR_OK:                  kind_crc = `MGW_CRC_ERROK;
      default:                             kind_crc = `MGW_CRC_ERR;
    endcase
  endfunction

  // byte index wrapped onto the array
  function automatic logic [AW-1:0] bidx(logic [7:0] a, int i);
    bidx = AW'((a + 8'(i)) % MEM_BYTES);
  endfunction

  logic [7:0]    mem [MEM_BYTES];
  logic          lck [MEM_BYTES];
  logic          en_r, wok_r, de_r, busy_r;
  logic [`MGW_EVW-1:0] ist_r, imask_r, ev, ist_nxt;
  logic [7:0]    maddr_r, qaddr_r;
  logic [31:0]   qdata_r;
  logic [3:0]    wen_r;
  logic          qok_r, done_p;
  logic [CW-1:0] cnt_r;
  logic          acc, wr_acc, cmd_ok, fast, bqw_go;
  logic [3:0]    sel, lk;
  logic [AW-1:0] ma;

  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite && !pslverr;
  assign ma     = AW'(maddr_r % MEM_BYTES);
  assign cmd_ok = cmd.valid && en_r && !busy_r;
  assign fast   = cmd.delim == `MGW_FAST_DELIM;
  assign bqw_go = cmd_ok && cmd.code == mgw_pkg::CMD_BQW &&
                  (tag_state == mgw_pkg::TS_ID ||
                   tag_state == mgw_pkg::TS_DE);

  // mask bits 7..4 pick start+0..start+3, lock read per byte
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sel[i] = cmd.mask[7-i];
      lk[i]  = lck[bidx(cmd.addr, i)];
    end
  end

  // apb handshake: no wait state, pready and prdata from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= psel && !penable && !pready;
      pslverr <= 1'b0;
      if (psel && !penable && !pready) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          `MGW_CTRL:  prdata <= {31'h0, en_r};
          `MGW_FLAGS: prdata <= {27'h0, busy_r, tag_state,
                                 wok_r, de_r};
          `MGW_ISTAT: prdata <= {29'h0, ist_r};
          `MGW_IMASK: prdata <= {29'h0, imask_r};
          `MGW_MADDR: prdata <= {24'h0, maddr_r};
          `MGW_MDATA: prdata <= {23'h0, lck[ma], mem[ma]};
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r    <= `MGW_CTRL_RST;
      imask_r <= '0;
      maddr_r <= 8'h00;
    end else if (ce && wr_acc) begin
      if (paddr == `MGW_CTRL)  en_r    <= pwdata[`MGW_CTRL_EN];
      if (paddr == `MGW_IMASK) imask_r <= pwdata[`MGW_EVW-1:0];
      if (paddr == `MGW_MADDR) maddr_r <= pwdata[7:0];
    end
  end

  // sticky events; a new event beats a write-one clear
  assign ev[`MGW_EV_OK]   = done_p && qok_r;
  assign ev[`MGW_EV_FAIL] = done_p && !qok_r;
  assign ev[`MGW_EV_DROP] = cmd.valid && cmd.code == mgw_pkg::CMD_BQW &&
                            !bqw_go;
  // next status first, so irq drops in the same cycle as the clear
  assign ist_nxt = (wr_acc && paddr == `MGW_ISTAT) ?
                   ((ist_r & ~pwdata[`MGW_EVW-1:0]) | ev) : (ist_r | ev);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
      irq   <= 1'b0;
    end else if (ce) begin
      ist_r <= ist_nxt;
      irq   <= |(ist_nxt & imask_r);
    end
  end

  // group write: latch, wait programming time, then commit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r  <= 1'b0;
      cnt_r   <= '0;
      wen_r   <= 4'h0;
      qok_r   <= 1'b0;
      qaddr_r <= 8'h00;
      qdata_r <= 32'h0000_0000;
      done_p  <= 1'b0;
    end else if (ce) begin
      done_p <= 1'b0;
      if (bqw_go) begin
        busy_r  <= 1'b1;
        cnt_r   <= CW'(PROG_CYC - 1);
        qaddr_r <= cmd.addr;
        qdata_r <= cmd.data;
        // misaligned start writes nothing and fails
        wen_r   <= (cmd.addr[1:0] == 2'b00) ? (sel & ~lk) : 4'h0;
        qok_r   <= cmd.addr[1:0] == 2'b00 && !(|(sel & lk));
      end else if (busy_r) begin
        if (cnt_r == '0) begin
          busy_r <= 1'b0;
          done_p <= 1'b1;
        end else begin
          cnt_r <= cnt_r - CW'(1);
        end
      end
    end
  end

  // byte array; software preload through the data window
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (busy_r && cnt_r == '0) begin
        for (int i = 0; i < 4; i++)
          if (wen_r[i]) mem[bidx(qaddr_r, i)] <= qdata_r[31-8*i -: 8];
      end else if (wr_acc && paddr == `MGW_MDATA) begin
        mem[ma] <= pwdata[7:0];
      end
    end
  end

  // lock bits: reset clears them, software may set or clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MEM_BYTES; i++) lck[i] <= 1'b0;
    end else if (ce && wr_acc && paddr == `MGW_MDATA) begin
      lck[ma] <= pwdata[`MGW_MD_LOCK];
    end
  end

  // status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wok_r    <= 1'b0;
      de_r     <= 1'b0;
      de_enter <= 1'b0;
    end else if (ce) begin
      de_enter <= cmd_ok && cmd.code == mgw_pkg::CMD_PORT &&
                  cmd.id_match;
      if (done_p) wok_r <= qok_r;
      if (cmd_ok && cmd.code == mgw_pkg::CMD_PORT && cmd.id_match)
        de_r <= 1'b1;
      else if (wr_acc && paddr == `MGW_CTRL && pwdata[`MGW_CTRL_DECLR])
        de_r <= 1'b0;
    end
  end

  // reply coder; group write never raises valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp <= '0;
    end else if (ce) begin
      rsp.valid     <= 1'b0;
      rsp.data      <= 8'h00;
      rsp.crc_fixed <= 1'b0;
      rsp.crc       <= 16'h0000;
      if (cmd_ok && cmd.id_match) begin
        unique case (cmd.code)
          mgw_pkg::CMD_WR, mgw_pkg::CMD_AQW,
          mgw_pkg::CMD_LOCK, mgw_pkg::CMD_LQ: begin
            // dummy byte, meaning only in crc when fast
            rsp.valid     <= 1'b1;
            rsp.crc_fixed <= fast;
            rsp.crc       <= fast ? kind_crc(cmd.rkind) : 16'h0000;
          end
          mgw_pkg::CMD_PORT: begin
            rsp.valid     <= 1'b1;
            rsp.data      <= (cmd.addr == 8'h00) ?
                             {6'h00, wok_r, de_r} : 8'h00;
            rsp.crc_fixed <= fast;
            if (!fast || cmd.addr != 8'h00) rsp.crc <= `MGW_CRC_ACK;
            else
              unique case ({wok_r, de_r})
                2'b00: rsp.crc <= `MGW_CRC_ACK;
                2'b01: rsp.crc <= `MGW_CRC_ACKOK;
                2'b10: rsp.crc <= `MGW_CRC_P0_WOK;
                2'b11: rsp.crc <= `MGW_CRC_P0_ALL;
              endcase
          end
          mgw_pkg::CMD_NONE, mgw_pkg::CMD_BQW,
          mgw_pkg::CMD_OTHER: rsp.valid <= 1'b0;
        endcase
      end
    end
  end

  // checks
  AST_STATE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy_r) |-> ($past(tag_state) == mgw_pkg::TS_ID ||
                       $past(tag_state) == mgw_pkg::TS_DE))
    else $error("group write accepted outside id or data exchange");
  AST_NO_REPLY: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && bqw_go) |=> !rsp.valid ##1 !rsp.valid)
    else $error("reply after group write");
  AST_LOCKED_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (busy_r && cnt_r == '0 && lck[bidx(qaddr_r, 1)] && ce) |=>
    mem[bidx(qaddr_r, 1)] == $past(mem[bidx(qaddr_r, 1)]))
    else $error("locked byte was programmed");
  AST_MASK_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && bqw_go && !cmd.mask[4]) |=> !wen_r[3])
    else $error("unselected fourth byte enabled");
  AST_WOK: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && done_p) |=> wok_r == $past(qok_r))
    else $error("write-success flag wrong after group write");
  AST_LOCK_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && bqw_go && |(sel & lk)) |-> ##1 !qok_r)
    else $error("locked selection still counted as success");
  AST_FAST_CRC: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cmd_ok && cmd.id_match && fast && cmd.code == mgw_pkg::CMD_LQ
     && cmd.rkind == mgw_pkg::RK_ERR_OK) |=>
    rsp.crc_fixed && rsp.crc == 16'h10de)
    else $error("fast error_ok crc wrong");
  AST_PORT0: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cmd_ok && cmd.id_match && fast && cmd.code == mgw_pkg::CMD_PORT
     && cmd.addr == 8'h00 && wok_r && !de_r) |=>
    rsp.crc == 16'h3e4d)
    else $error("port 0 fast crc wrong");
  AST_PORT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    rsp.valid |-> rsp.data[7:2] == 6'h00)
    else $error("unused flag bits not zero");
  AST_DE_ENTER: assert property (@(posedge pclk) disable iff (!presetn)
    de_enter |-> de_r && rsp.valid)
    else $error("port read did not enter data exchange");
  COV_GROUP_OK: cover property (@(posedge pclk) ev[`MGW_EV_OK]);
  COV_GROUP_FAIL: cover property (@(posedge pclk) ev[`MGW_EV_FAIL]);
  COV_FAST_PORT: cover property (@(posedge pclk)
    rsp.valid && rsp.crc_fixed && rsp.crc == 16'h2e6c);
endmodule
`default_nettype wire

// ==== dv/mgw_reader_model.sv ====
// reader model: frames commands, decodes fast replies by crc
// assumes the tag block samples cmd on the rising edge of pclk
`timescale 1ns/10ps
`default_nettype none
`include "mgw_map.svh"
module mgw_reader_model (
  // clock
  input  wire logic               pclk,
  // forward and return link
  output mgw_pkg::mgw_cmd_s_t     cmd,
  input  wire mgw_pkg::mgw_rsp_t  rsp
);
  int          rsp_cnt = 0;
  logic [2:0]  kind = 3'h0;
  logic [15:0] crc_seen = 16'h0000;
  logic [7:0]  data_seen = 8'h00;
  logic        fixed_seen = 1'b0;
  initial cmd = '0;
  // one-cycle frame; group write uses the single delimiter, no wait
  task automatic send(input mgw_pkg::mgw_cmd_t c, input logic f,
                      input logic [7:0] a, input logic [7:0] m,
                      input logic [31:0] d, input mgw_pkg::mgw_rkind_t k);
    @(posedge pclk);
    cmd <= '{1'b1, c, f ? `MGW_FAST_DELIM : 11'h000, 1'b1, a, m, d, k};
    @(posedge pclk);
    cmd.valid <= 1'b0;
    // released data and mask show garbage, not the last frame
    cmd.data <= ~d;
    cmd.mask <= ~m;
  endtask
  // meaning taken from the crc alone, data byte only logged
  always @(posedge pclk) begin
    if (rsp.valid === 1'b1) begin
      rsp_cnt++;
      crc_seen = rsp.crc;
      data_seen = rsp.data;
      fixed_seen = rsp.crc_fixed;
      case (rsp.crc)
        16'h1e0f: kind = 3'h0;
        16'h0e2e: kind = 3'h2;
        16'h00ff: kind = 3'h4;
        16'h10de: kind = 3'h5;
        default:  kind = 3'h7;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== dv/masked_group_write_fast_return_tb_top.sv ====
// bench for the masked group write and fast return block
// assumes the reader model drives cmd and apb reaches the registers
`timescale 1ns/10ps
`default_nettype none
`include "mgw_map.svh"
module masked_group_write_fast_return_tb_top;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 de_enter;
  logic                 irq;
  logic [31:0]          q;
  logic                 serr;
  int                   errors = 0;
  int                   compares = 0;
  int                   de_cnt = 0;
  mgw_pkg::mgw_tstate_t tag_state = mgw_pkg::TS_READY;
  mgw_pkg::mgw_cmd_s_t  cmd;
  mgw_pkg::mgw_rsp_t    rsp;
  logic [15:0]          crc_t [6] = '{16'h1e0f, 16'h1e0f, 16'h0e2e,
                                      16'h00ff, 16'h00ff, 16'h10de};
  mgw_pkg::mgw_cmd_t    rcmd [4] = '{mgw_pkg::CMD_WR, mgw_pkg::CMD_AQW,
                                     mgw_pkg::CMD_LOCK, mgw_pkg::CMD_LQ};
  logic [2:0]           kind_t [6] = '{3'h0, 3'h0, 3'h2, 3'h4, 3'h4, 3'h5};
  always #2.5 pclk = ~pclk;
  // each port read that pulses de_enter is counted for the closing check, including reads made while already in data exchange
  always @(posedge pclk) if (de_enter === 1'b1) de_cnt++;
  mgw_top #(.MEM_BYTES(64), .PROG_CYC(8)) dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd),
    .tag_state(tag_state), .rsp(rsp), .de_enter(de_enter), .irq(irq));
  mgw_reader_model rdr (.pclk(pclk), .cmd(cmd), .rsp(rsp));
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      print_verdict();
    end
  endtask
  // group write, then poll busy with a bounded count
  task automatic bqw(input logic [7:0] a, input logic [7:0] m);
    int n;
    rdr.send(mgw_pkg::CMD_BQW, 1'b0, a, m, 32'ha5c3_1e77, mgw_pkg::RK_ACK);
    n = 0;
    do begin
      apb(1'b0, `MGW_FLAGS, 32'h0);
      n++;
    end while (q[4] !== 1'b0 && n < 30);
    if (n >= 30) begin
      errors++;
      print_verdict();
    end
    apb(1'b0, `MGW_FLAGS, 32'h0);
  endtask
  task automatic port(input logic f, input logic [7:0] p);
    rdr.send(mgw_pkg::CMD_PORT, f, p, 8'h00, 32'h0, mgw_pkg::RK_ACK);
    repeat (3) @(posedge pclk);
  endtask
  // irq settles at most one edge after the last register change
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // one byte and its lock bit read back through the data window
  task automatic chk_byte(input logic [7:0] a, input logic [31:0] e);
    apb(1'b1, `MGW_MADDR, {24'h0, a});
    apb(1'b0, `MGW_MDATA, 32'h0);
    chk(q, e);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MGW_FLAGS, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `MGW_MADDR, 32'h5);
    apb(1'b1, `MGW_MDATA, 32'h100);
    apb(1'b1, `MGW_IMASK, 32'h3);
    // dropped outside identification and data exchange
    tag_state <= mgw_pkg::TS_READY;
    bqw(8'h04, 8'hb0);
    chk(q & 32'h3, 32'h0);
    tag_state <= mgw_pkg::TS_QUIET;
    bqw(8'h04, 8'hb0);
    apb(1'b0, `MGW_ISTAT, 32'h0);
    chk(q, 32'h4);
    apb(1'b1, `MGW_ISTAT, 32'h4);
    // mask skips the locked byte at start+1
    tag_state <= mgw_pkg::TS_ID;
    bqw(8'h04, 8'hb0);
    chk(q & 32'h3, 32'h2);
    apb(1'b0, `MGW_ISTAT, 32'h0);
    chk(q, 32'h1);
    chk_byte(8'h04, 32'ha5);
    chk_irq(1'b1);
    apb(1'b1, `MGW_IMASK, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, `MGW_IMASK, 32'h3);
    apb(1'b1, `MGW_ISTAT, 32'h1);
    bqw(8'h04, 8'hf0);
    chk(q & 32'h3, 32'h0);
    apb(1'b0, `MGW_ISTAT, 32'h0);
    chk(q, 32'h2);
    chk_byte(8'h05, 32'h100);
    chk_irq(1'b1);
    apb(1'b1, `MGW_ISTAT, 32'h2);
    chk_irq(1'b0);
    tag_state <= mgw_pkg::TS_DE;
    apb(1'b1, `MGW_MADDR, 32'hb);
    apb(1'b1, `MGW_MDATA, 32'h5a);
    bqw(8'h08, 8'h60);
    chk(q & 32'h3, 32'h2);
    chk_byte(8'h0b, 32'h5a);
    chk_byte(8'h0a, 32'h1e);
    bqw(8'h06, 8'hf0);
    chk(q & 32'h3, 32'h0);
    chk_byte(8'h06, 32'h1e);
    chk(rdr.rsp_cnt, 32'h0);
    // port reads, fast except the last, flags de set and write-success varied
    port(1'b1, 8'h00);
    apb(1'b0, `MGW_FLAGS, 32'h0);
    chk(q, 32'h9);
    port(1'b1, 8'h00);
    chk({rdr.fixed_seen, rdr.crc_seen}, {1'b1, 16'h0e2e});
    bqw(8'h08, 8'h30);
    port(1'b1, 8'h00);
    chk(rdr.crc_seen, 16'h2e6c);
    port(1'b1, 8'h09);
    chk(rdr.crc_seen, 16'h1e0f);
    port(1'b0, 8'h00);
    chk({rdr.fixed_seen, rdr.data_seen}, {1'b0, 8'h03});
    // clear the data exchange flag, write-success alone stays
    apb(1'b1, `MGW_CTRL, 32'h3);
    port(1'b1, 8'h00);
    chk({rdr.fixed_seen, rdr.crc_seen}, {1'b1, 16'h3e4d});
    // every reply kind; the offset pairs the lock query with error_ok
    for (int i = 0; i < 6; i++) begin
      rdr.send(rcmd[(i + 2) % 4], 1'b1, 8'h04, 8'h00, 32'h0,
               mgw_pkg::mgw_rkind_t'(i));
      repeat (3) @(posedge pclk);
      chk({rdr.kind, rdr.fixed_seen, rdr.data_seen, rdr.crc_seen},
          {kind_t[i], 1'b1, 8'h00, crc_t[i]});
    end
    chk(rdr.rsp_cnt, 32'd12);
    // disabled block stays silent on the return link
    apb(1'b1, `MGW_CTRL, 32'h0);
    port(1'b1, 8'h00);
    chk(rdr.rsp_cnt, 32'd12);
    chk(de_cnt, 32'd6);
    apb(1'b0, 12'h020, 32'h0);
    chk({serr, q}, {1'b1, 32'h0});
    print_verdict();
  end
endmodule
`default_nettype wire
